/* src/urx_pkg.sv */
// Purpose: shared constants and types of the serial receive channel
// Assumes: one channel, host register map at four address bits
// Notes:   host register reset values are zero
package urx_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0] A_MODE  = 4'h0; // mode one / mode two
    localparam logic [3:0] A_STAT  = 4'h1; // read status, write clock select
    localparam logic [3:0] A_CMD   = 4'h2; // write command
    localparam logic [3:0] A_HOLD  = 4'h3; // read holding queue
    localparam logic [3:0] A_OPSET = 4'hE; // set output port bits
    localparam logic [3:0] A_OPCLR = 4'hF; // clear output port bits
    localparam logic [7:0] RST_VAL = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int MR1_RTS    = 7;
    localparam int MR1_INTSEL = 6;
    localparam int MR1_BLOCK  = 5;
    localparam int MR1_PTYPE  = 2;
    localparam int CSR_RX1X   = 7; // receiver takes the 1X bit clock
    localparam int CMD_EN     = 0;
    localparam int CMD_DIS    = 1;
    localparam int OPR_RTS    = 0;
    localparam logic [1:0] PM_WITH  = 2'h0;
    localparam logic [1:0] PM_FORCE = 2'h1;
    localparam logic [1:0] PM_NONE  = 2'h2;
    localparam logic [1:0] PM_MDROP = 2'h3;
    localparam logic [2:0] MISC_RSTPTR = 3'h1;
    localparam logic [2:0] MISC_RSTRX  = 3'h2;
    localparam logic [2:0] MISC_RSTERR = 3'h4;

    // ************************************************************
    // timing and sizes
    // ************************************************************
    localparam logic [3:0] HALF16 = 4'h7; // 16X ticks to the start check, minus one
    localparam logic [3:0] BIT16  = 4'hF; // 16X ticks per bit, minus one
    localparam logic [3:0] ONE1X  = 4'h0; // 1X: next rising edge
    localparam logic [1:0] DEPTH  = 2'h3;

    typedef struct packed {
        logic       brk;
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } urx_char_s;

    typedef enum logic [2:0] {
        S_IDLE, S_START, S_DATA, S_PAR, S_STOP, S_FEWAIT, S_BRKWAIT
    } urx_state_e;

endpackage

/* src/urx_channel.sv */
// Purpose: receive side of one asynchronous serial channel with host registers
// Assumes: host strobes and serial inputs are synchronous to clk
// Notes:   each clock with cs_n and rd_n low is one read access
//
// Contract
// - enabled receiver hunts falling edge for start
// - recheck start after half bit, high rejects
// - sample bit centres through data, parity, stop
// - least bit first, queue char, set ready
// - unused upper data bits read zero
// - resume hunt; low after framing restarts
// - errors latched with char before ready
// - all-low char loads zero, sets break
// - three-deep queue fills behind held chars
// - ready when any held, full when three
// - holding read returns oldest then pops
// - each char keeps parity, framing, break
// - character mode head only, block ORs
// - status read never pops the queue
// - full queue: wait, overrun on next start
// - flow control drops request on full start
// - disabled receiver keeps queue, takes only multidrop address chars
// - receiver reset clears queue and status
// - mode field eleven selects multidrop tag
// - disabled multidrop queues address chars only
// - tag stored in parity slot
// - mode pointer steps one to two
// - mode bit six picks interrupt source
// - mode low bits set data length
// - mode bit five picks error reporting
`timescale 1ns/1ps
`default_nettype none
module urx_channel (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    input  wire logic       rxd,
    input  wire logic       rx_tick16,
    input  wire logic       rx_clk1x,
    input  wire logic       tx_empty,
    input  wire logic       tx_ready,
    output logic            request_send_out_n,
    output logic            rx_char_available,
    output logic            queue_full_flag,
    output logic            rx_int_req
);

    // ************************************************************
    // host access decode
    // ************************************************************
    logic rd;
    logic wr;
    logic rsterr;
    logic rxrst;
    logic [2:0] misc;
    assign rd     = !cs_n && !rd_n;
    assign wr     = !cs_n && !wr_n;
    assign misc   = wdata[6:4];
    assign rsterr = wr && addr == urx_pkg::A_CMD && misc == urx_pkg::MISC_RSTERR;
    assign rxrst  = wr && addr == urx_pkg::A_CMD && misc == urx_pkg::MISC_RSTRX;

    logic [7:0] mr1_q, mr1_d, mr2_q, mr2_d, csr_q, csr_d, opr_q, opr_d;
    logic       ptr_q, ptr_d;
    logic       en_q, en_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] status;
    logic [1:0] pm;
    logic       mdrop;
    assign pm    = mr1_q[4:3];
    assign mdrop = pm == urx_pkg::PM_MDROP;

    // queue state, declared early for the read mux
    urx_pkg::urx_char_s q_q [3];
    urx_pkg::urx_char_s q_d [3];
    logic [1:0] cnt_q, cnt_d;
    logic       full;
    logic [2:0] acc_q, acc_d;
    logic       ovr_q, ovr_d;
    assign full = cnt_q == urx_pkg::DEPTH;

    // status word: head or block-accumulated errors above live flags
    always_comb begin
        logic [2:0] err;
        err = '0;
        if (mr1_q[urx_pkg::MR1_BLOCK]) begin
            err = acc_q;
        end else if (cnt_q != 2'h0) begin
            err = {q_q[0].brk, q_q[0].fe, q_q[0].pe};
        end
        status = {err, ovr_q, tx_empty, tx_ready, full, cnt_q != 2'h0};
    end

    // mode pointer, control registers and read data
    always_comb begin
        mr1_d   = mr1_q;
        mr2_d   = mr2_q;
        csr_d   = csr_q;
        opr_d   = opr_q;
        ptr_d   = ptr_q;
        en_d    = en_q;
        rdata_d = rdata_q;
        if ((rd || wr) && addr == urx_pkg::A_MODE) begin
            ptr_d = 1'b1;
            if (wr && !ptr_q) begin
                mr1_d = wdata;
            end
            if (wr && ptr_q) begin
                mr2_d = wdata;
            end
        end
        if (wr && addr == urx_pkg::A_STAT) begin
            csr_d = wdata;
        end
        if (wr && addr == urx_pkg::A_OPSET) begin
            opr_d = opr_q | wdata;
        end
        if (wr && addr == urx_pkg::A_OPCLR) begin
            opr_d = opr_q & ~wdata;
        end
        if (wr && addr == urx_pkg::A_CMD) begin
            if (misc == urx_pkg::MISC_RSTPTR) begin
                ptr_d = 1'b0;
            end
            if (wdata[urx_pkg::CMD_EN]) begin
                en_d = 1'b1;
            end
            // disable wins over enable; reset halts until a later enable
            if (wdata[urx_pkg::CMD_DIS] || rxrst) begin
                en_d = 1'b0;
            end
        end
        // a status read only copies the word; the queue moves on hold reads
        if (rd) begin
            case (addr)
                urx_pkg::A_MODE: rdata_d = ptr_q ? mr2_q : mr1_q;
                urx_pkg::A_STAT: rdata_d = status;
                urx_pkg::A_HOLD: rdata_d = cnt_q != 2'h0 ? q_q[0].data : '0;
                default:         rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mr1_q   <= urx_pkg::RST_VAL;
            mr2_q   <= urx_pkg::RST_VAL;
            csr_q   <= urx_pkg::RST_VAL;
            opr_q   <= urx_pkg::RST_VAL;
            ptr_q   <= 1'b0;
            en_q    <= 1'b0;
            rdata_q <= urx_pkg::RST_VAL;
        end else begin
            mr1_q   <= mr1_d;
            mr2_q   <= mr2_d;
            csr_q   <= csr_d;
            opr_q   <= opr_d;
            ptr_q   <= ptr_d;
            en_q    <= en_d;
            rdata_q <= rdata_d;
        end
    end
    assign rdata = rdata_q;

    // ************************************************************
    // bit timing and receive sequencer
    // ************************************************************
    logic       rxd_q, c1x_q;
    logic       mode1x, tick;
    logic [3:0] half_n, bit_n;
    logic [2:0] last_bit;
    assign mode1x   = csr_q[urx_pkg::CSR_RX1X];
    assign tick     = mode1x ? (rx_clk1x && !c1x_q) : rx_tick16;
    assign half_n   = mode1x ? urx_pkg::ONE1X : urx_pkg::HALF16;
    assign bit_n    = mode1x ? urx_pkg::ONE1X : urx_pkg::BIT16;
    assign last_bit = {1'b1, mr1_q[1:0]};

    urx_pkg::urx_state_e st_q, st_d;
    logic [3:0] tc_q, tc_d;
    logic [2:0] nb_q, nb_d;
    logic [7:0] sh_q, sh_d;
    logic       par_q, par_d;
    logic       start_ok, done;
    urx_pkg::urx_char_s done_c;
    logic       listen, at_ctr;
    // a disabled receiver hunts only in multidrop mode
    assign listen = en_q || mdrop;
    assign at_ctr = tick && tc_q == 4'h0;

    always_comb begin
        logic zero;
        st_d     = st_q;
        tc_d     = tc_q;
        nb_d     = nb_q;
        sh_d     = sh_q;
        par_d    = par_q;
        start_ok = 1'b0;
        done     = 1'b0;
        done_c   = '0;
        zero     = sh_q == 8'h00 && !par_q;
        if (tick && tc_q != 4'h0) begin
            tc_d = tc_q - 4'h1;
        end
        case (st_q)
            urx_pkg::S_IDLE: begin
                if (listen && rxd_q && !rxd) begin
                    st_d = urx_pkg::S_START;
                    tc_d = half_n;
                end
            end
            urx_pkg::S_START: begin
                if (at_ctr) begin
                    if (rxd) begin
                        st_d = urx_pkg::S_IDLE;
                    end else begin
                        start_ok = 1'b1;
                        st_d     = urx_pkg::S_DATA;
                        tc_d     = bit_n;
                        nb_d     = '0;
                        sh_d     = '0; // unused upper bits stay zero
                        par_d    = 1'b0;
                    end
                end
            end
            urx_pkg::S_DATA: begin
                if (at_ctr) begin
                    sh_d[nb_q] = rxd;
                    nb_d       = nb_q + 3'h1;
                    tc_d       = bit_n;
                    if (nb_q == last_bit) begin
                        st_d = pm == urx_pkg::PM_NONE ? urx_pkg::S_STOP : urx_pkg::S_PAR;
                    end
                end
            end
            urx_pkg::S_PAR: begin
                if (at_ctr) begin
                    par_d = rxd;
                    tc_d  = bit_n;
                    st_d  = urx_pkg::S_STOP;
                end
            end
            urx_pkg::S_STOP: begin
                if (at_ctr) begin
                    done        = 1'b1;
                    done_c.data = sh_q;
                    case (pm)
                        urx_pkg::PM_WITH:  done_c.pe = ^{sh_q, par_q} != mr1_q[urx_pkg::MR1_PTYPE];
                        urx_pkg::PM_FORCE: done_c.pe = par_q != mr1_q[urx_pkg::MR1_PTYPE];
                        urx_pkg::PM_MDROP: done_c.pe = par_q;
                        default:           done_c.pe = 1'b0;
                    endcase
                    tc_d = half_n;
                    if (rxd) begin
                        st_d = urx_pkg::S_IDLE;
                    end else if (zero) begin
                        done_c.pe  = 1'b0;
                        done_c.brk = 1'b1;
                        st_d       = urx_pkg::S_BRKWAIT;
                    end else begin
                        done_c.fe = 1'b1;
                        st_d      = urx_pkg::S_FEWAIT;
                    end
                end
            end
            urx_pkg::S_FEWAIT: begin
                // still low half a bit after a bad stop counts as a new start edge
                if (at_ctr) begin
                    st_d = rxd ? urx_pkg::S_IDLE : urx_pkg::S_START;
                    tc_d = half_n;
                end
            end
            urx_pkg::S_BRKWAIT: begin
                if (!rxd) begin
                    tc_d = half_n; // any low restarts the high-time count
                end else if (at_ctr) begin
                    st_d = urx_pkg::S_IDLE;
                end
            end
            default: st_d = urx_pkg::S_IDLE;
        endcase
        if (rxrst) begin
            st_d = urx_pkg::S_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q  <= urx_pkg::S_IDLE;
            tc_q  <= '0;
            nb_q  <= '0;
            sh_q  <= '0;
            par_q <= 1'b0;
            rxd_q <= 1'b1;
            c1x_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            tc_q  <= tc_d;
            nb_q  <= nb_d;
            sh_q  <= sh_d;
            par_q <= par_d;
            rxd_q <= rxd;
            c1x_q <= rx_clk1x;
        end
    end

    // ************************************************************
    // waiting character, holding queue and error status
    // ************************************************************
    logic                 pv_q, pv_d;
    urx_pkg::urx_char_s   pc_q, pc_d;
    logic                 push, pop, keep, head_ev;
    logic                 request_send_out_n_q, request_send_out_n_d;
    // data-tagged chars of a disabled multidrop receiver are dropped
    assign keep = en_q || (mdrop && done_c.pe);
    assign push = pv_q && !full;
    assign pop  = rd && addr == urx_pkg::A_HOLD && cnt_q != 2'h0;

    // queue moves down one place on pop, new char fills first free place
    always_comb begin
        logic [1:0] wi;
        wi    = cnt_q - {1'b0, pop};
        cnt_d = cnt_q - {1'b0, pop} + {1'b0, push};
        for (int i = 0; i < 3; i++) begin
            q_d[i] = q_q[i];
            if (pop && i < 2) begin
                q_d[i] = q_q[(i + 1) % 3]; // index wraps only to stay in range
            end
            if (push && wi == i[1:0]) begin
                q_d[i] = pc_q;
            end
        end
        if (rxrst) begin
            cnt_d = '0;
        end
    end

    // waiting char, overrun, block errors and flow control
    always_comb begin
        pv_d    = pv_q && !push;
        pc_d    = pc_q;
        head_ev = cnt_d != 2'h0 && (pop || cnt_q == 2'h0); // pop and push together too
        ovr_d   = rsterr ? 1'b0 : ovr_q;
        acc_d   = rsterr ? 3'h0 : acc_q;
        request_send_out_n_d  = full ? request_send_out_n_q : 1'b0;
        // the set wins over a reset-error in the same cycle
        if (start_ok && pv_q && full) begin
            ovr_d = 1'b1;
        end
        if (head_ev) begin
            acc_d = acc_d | {q_d[0].brk, q_d[0].fe, q_d[0].pe};
        end
        if (start_ok && full && mr1_q[urx_pkg::MR1_RTS]) begin
            request_send_out_n_d = 1'b1;
        end
        if (done && keep) begin
            pv_d = 1'b1; // an unpushed older char is overwritten
            pc_d = done_c;
        end
        if (rxrst) begin
            pv_d   = 1'b0;
            ovr_d  = 1'b0;
            acc_d  = '0;
            request_send_out_n_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q  <= '0;
            pv_q   <= 1'b0;
            pc_q   <= '0;
            ovr_q  <= 1'b0;
            acc_q  <= '0;
            request_send_out_n_q <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                q_q[i] <= '0;
            end
        end else begin
            cnt_q  <= cnt_d;
            pv_q   <= pv_d;
            pc_q   <= pc_d;
            ovr_q  <= ovr_d;
            acc_q  <= acc_d;
            request_send_out_n_q <= request_send_out_n_d;
            for (int i = 0; i < 3; i++) begin
                q_q[i] <= q_d[i];
            end
        end
    end

    // request follows the port bit unless the receiver holds it off
    assign request_send_out_n = !(opr_q[urx_pkg::OPR_RTS] && !request_send_out_n_q);
    assign rx_char_available  = cnt_q != 2'h0;
    assign queue_full_flag    = full;
    assign rx_int_req = mr1_q[urx_pkg::MR1_INTSEL] ? full : rx_char_available;

endmodule
`default_nettype wire

/* bench/urx_channel_properties.sv */
// Purpose: port-level properties of the receive channel
// Assumes: bound to every urx_channel instance
// Notes:   only the ports are seen, so mode-dependent checks stay coarse
`timescale 1ns/1ps
`default_nettype none
module urx_channel_properties (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       rxd,
    input wire logic       rx_tick16,
    input wire logic       rx_clk1x,
    input wire logic       tx_empty,
    input wire logic       tx_ready,
    input wire logic       request_send_out_n,
    input wire logic       rx_char_available,
    input wire logic       queue_full_flag,
    input wire logic       rx_int_req
);
    // ********************************************
    // decoded host accesses
    // ********************************************
    logic hold_rd;
    logic stat_rd;
    logic any_wr;
    logic opclr_wr;
    assign hold_rd  = !cs_n && !rd_n && wr_n && addr == urx_pkg::A_HOLD;
    assign stat_rd  = !cs_n && !rd_n && wr_n && addr == urx_pkg::A_STAT;
    assign any_wr   = !cs_n && !wr_n;
    assign opclr_wr = any_wr && addr == urx_pkg::A_OPCLR;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_full_pop;
        hold_rd ##0 queue_full_flag;
    endsequence
    sequence s_full_peek;
        stat_rd ##0 queue_full_flag;
    endsequence

    // ********************************************
    // assertions
    // ********************************************
    chk_reset_quiet: assert property ($rose(nrst) |-> !rx_char_available &&
        !queue_full_flag && request_send_out_n && rdata == 8'h00)
        else $error("outputs not cleared by reset");
    chk_full_has_char: assert property (queue_full_flag |-> rx_char_available)
        else $error("full flag without a held character");
    chk_int_source: assert property (rx_int_req |-> rx_char_available)
        else $error("interrupt request with an empty queue");
    chk_peek_keeps: assert property (s_full_peek |=> queue_full_flag)
        else $error("status read changed the queue");
    chk_pop_frees: assert property (s_full_pop |=> !queue_full_flag)
        else $error("holding read did not free a position");
    chk_empty_read: assert property (hold_rd && !rx_char_available |=> rdata == 8'h00)
        else $error("empty holding read returned data");
    chk_rdata_holds: assert property ((cs_n || rd_n) |=> $stable(rdata))
        else $error("read data changed without a read");
    chk_queue_kept: assert property (rx_char_available && !hold_rd && !any_wr
        |=> rx_char_available)
        else $error("held character vanished without a read");
    chk_rts_cause: assert property ($rose(request_send_out_n)
        |-> $past(queue_full_flag) || $past(opclr_wr))
        else $error("request to send dropped without cause");
endmodule

bind urx_channel urx_channel_properties u_chk (
    .clk(clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rxd(rxd), .rx_tick16(rx_tick16),
    .rx_clk1x(rx_clk1x), .tx_empty(tx_empty), .tx_ready(tx_ready),
    .request_send_out_n(request_send_out_n), .rx_char_available(rx_char_available),
    .queue_full_flag(queue_full_flag), .rx_int_req(rx_int_req));
`default_nettype wire

/* bench/urx_serial_src.sv */
// Purpose: remote serial transmitter and 16X tick source
// Assumes: four clk cycles per 16X tick
// Notes:   line rests at mark between frames
`timescale 1ns/1ps
`default_nettype none
module urx_serial_src (
    input  wire logic clk,
    output logic      rxd,
    output logic      rx_tick16
);
    logic [1:0] div_q;
    initial begin
        rxd   = 1'b1; // idle mark level
        div_q = 2'h0;
    end
    // free running divider; send moves the line only on its ticks
    always @(negedge clk) begin
        div_q <= div_q + 2'h1;
    end
    assign rx_tick16 = (div_q == 2'h3);

    task automatic tk(input int k);
        repeat (k) begin
            @(negedge clk);
            while (!rx_tick16) @(negedge clk);
        end
    endtask

    // bits holds data, then tag or parity, then stop; gap gives slow senders
    task automatic send(input logic [9:0] bits, input int n, input int gap);
        integer j;
        tk(gap + 1);
        rxd = 1'b0;
        tk(16);
        for (j = 0; j < n; j++) begin
            rxd = bits[j]; // least bit first, tag after data
            tk(16);
        end
        rxd = 1'b1;
    endtask
endmodule
`default_nettype wire

/* bench/urx_channel_tb_top.sv */
// Purpose: self-checking bench of the receive channel
// Assumes: host strobes change on falling clk edges
// Notes:   the 1X bit clock is driven only in the last scenario
`timescale 1ns/1ps
`default_nettype none
module urx_channel_tb_top;
    logic       clk;
    logic       nrst;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       rx_clk1x;
    logic       tx_empty;
    logic       tx_ready;
    wire  [7:0] rdata;
    wire        rxd;
    wire        rx_tick16;
    wire        request_send_out_n;
    wire        rx_char_available;
    wire        queue_full_flag;
    wire        rx_int_req;
    int         n_fail;
    int         n_compared;
    integer     seed;
    int         i;
    logic [7:0] r;
    logic [7:0] c [0:4];
    logic [4:0] d;
    logic [9:0] b;

    urx_channel dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .wdata(wdata), .rdata(rdata), .rxd(rxd), .rx_tick16(rx_tick16),
        .rx_clk1x(rx_clk1x), .tx_empty(tx_empty), .tx_ready(tx_ready),
        .request_send_out_n(request_send_out_n), .rx_char_available(rx_char_available),
        .queue_full_flag(queue_full_flag), .rx_int_req(rx_int_req));
    urx_serial_src src (.clk(clk), .rxd(rxd), .rx_tick16(rx_tick16));

    always #4 clk = ~clk;

    // ********************************************
    // helpers
    // ********************************************
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge clk);
        cs_n  = 1'b0;
        wr_n  = 1'b0;
        addr  = a;
        wdata = v;
        @(negedge clk);
        cs_n = 1'b1;
        wr_n = 1'b1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(negedge clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        addr = a;
        @(negedge clk);
        cs_n = 1'b1;
        rd_n = 1'b1;
        v    = rdata;
    endtask
    // expected status: queued errors over live flags
    function automatic logic [7:0] stat(input logic [2:0] up, input logic ov,
                                        input logic fl, input logic av);
        return {up, ov, tx_empty, tx_ready, fl, av};
    endfunction
    function automatic logic [7:0] bit8(input logic v);
        return {7'h00, v};
    endfunction

    // hang guard, well above the longest expected run
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        results();
    end

    // ********************************************
    // main sequence
    // ********************************************
    initial begin
        seed = 7;
        clk = 1'b0;
        nrst = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        rx_clk1x = 1'b0;
        tx_empty = 1'($random(seed));
        tx_ready = 1'($random(seed));
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        chk(rdata, 8'h00);
        wr(urx_pkg::A_MODE, 8'h93); // flow control, no parity, eight bits
        wr(urx_pkg::A_MODE, 8'h00);
        wr(urx_pkg::A_CMD, 8'h10);
        rd(urx_pkg::A_MODE, r);
        chk(r, 8'h93);
        wr(urx_pkg::A_OPSET, 8'h01);
        wr(urx_pkg::A_CMD, 8'h01);
        chk(bit8(request_send_out_n), 8'h00);
        // three back to back fill the queue, a fourth waits, a fifth overruns it
        for (i = 0; i < 5; i++) begin
            c[i] = 8'($random(seed));
            src.send({2'b11, c[i]}, 9, i);
            if (i == 2) begin
                repeat (4) @(negedge clk);
                rd(urx_pkg::A_STAT, r);
                chk(r, stat(3'h0, 1'b0, 1'b1, 1'b1));
            end
        end
        repeat (4) @(negedge clk);
        rd(urx_pkg::A_STAT, r);
        chk(r, stat(3'h0, 1'b1, 1'b1, 1'b1));
        chk(bit8(request_send_out_n), 8'h01);
        c[3] = c[4];
        for (i = 0; i < 4; i++) begin
            rd(urx_pkg::A_HOLD, r);
            chk(r, c[i]);
            repeat (2) @(negedge clk);
            chk(bit8(request_send_out_n), 8'h00);
        end
        rd(urx_pkg::A_HOLD, r);
        chk(r, 8'h00);
        wr(urx_pkg::A_CMD, 8'h40);
        rd(urx_pkg::A_STAT, r);
        chk(r, stat(3'h0, 1'b0, 1'b0, 1'b0));
        // a disabled receiver outside multidrop takes nothing
        wr(urx_pkg::A_CMD, 8'h02);
        src.send({2'b11, 8'h5A}, 9, 2);
        repeat (4) @(negedge clk);
        chk(bit8(rx_char_available), 8'h00);
        // five bits, even parity: parity, framing and break errors
        wr(urx_pkg::A_CMD, 8'h20);
        wr(urx_pkg::A_CMD, 8'h10);
        wr(urx_pkg::A_MODE, 8'h00);
        wr(urx_pkg::A_CMD, 8'h01);
        for (i = 0; i < 3; i++) begin
            d = 5'($random(seed));
            if (i == 0) b = {4'h1, ~(^d), d};
            else if (i == 1) b = {4'h0, ^(d | 5'h01), d | 5'h01};
            else b = 10'h000;
            src.send(b, 7, 16);
            repeat (4) @(negedge clk);
            rd(urx_pkg::A_STAT, r);
            chk(r, stat(3'h1 << i, 1'b0, 1'b0, 1'b1));
            rd(urx_pkg::A_HOLD, r);
            chk(r, {3'h0, b[4:0]});
        end
        // block mode shows the OR of every head since the last reset-error
        wr(urx_pkg::A_CMD, 8'h10);
        wr(urx_pkg::A_MODE, 8'h20);
        tx_empty = ~tx_empty;
        tx_ready = ~tx_ready;
        rd(urx_pkg::A_STAT, r);
        chk(r, stat(3'h7, 1'b0, 1'b0, 1'b0));
        wr(urx_pkg::A_CMD, 8'h40);
        rd(urx_pkg::A_STAT, r);
        chk(r, stat(3'h0, 1'b0, 1'b0, 1'b0));
        // multidrop while disabled: only the address-tagged char is queued
        wr(urx_pkg::A_CMD, 8'h20);
        wr(urx_pkg::A_CMD, 8'h10);
        wr(urx_pkg::A_MODE, 8'h5B);
        c[0] = 8'($random(seed));
        src.send({2'b10, c[0]}, 10, 16);
        repeat (4) @(negedge clk);
        chk(bit8(rx_char_available), 8'h00);
        src.send({2'b11, c[0]}, 10, 3);
        repeat (4) @(negedge clk);
        chk(bit8(rx_int_req), 8'h00);
        rd(urx_pkg::A_STAT, r);
        chk(r, stat(3'h1, 1'b0, 1'b0, 1'b1));
        rd(urx_pkg::A_HOLD, r);
        chk(r, c[0]);
        // enabled multidrop on the 1X bit clock keeps a data-tagged char
        wr(urx_pkg::A_STAT, 8'h80);
        wr(urx_pkg::A_CMD, 8'h01);
        fork
            src.send({2'b10, c[1]}, 10, 0);
            begin
                src.tk(9); // rising edges land in mid bit
                repeat (11) begin
                    rx_clk1x = 1'b1;
                    src.tk(8);
                    rx_clk1x = 1'b0;
                    src.tk(8);
                end
            end
        join
        repeat (4) @(negedge clk);
        rd(urx_pkg::A_STAT, r);
        chk(r, stat(3'h0, 1'b0, 1'b0, 1'b1));
        rd(urx_pkg::A_HOLD, r);
        chk(r, c[1]);
        results();
    end
endmodule
`default_nettype wire
